// ### rtl/ten_bit_compare_pwm_timer.sv
`timescale 1ns/1ns
module ten_bit_compare_pwm_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             timer_output_pin,
    output logic             timer_output_enable
);
    localparam int unsigned W = ten_bit_timer_pkg::CNT_W;

    // P meets only the top bits, so its field must end where the count ends
    if (ten_bit_timer_pkg::CMP_P_W + ten_bit_timer_pkg::P_SHIFT != W) begin : g_width_check
        $error("compare P field does not line up with the counter top");
    end

    logic [7:0]   control0_q;
    logic [7:0]   control1_q;
    logic [W-1:0] compare_a_value_q;
    logic [W-1:0] counter_q;
    logic         match_a_flag_q;
    logic         match_p_flag_q;
    logic         run_prev_q;
    logic         pin_state_q;
    logic         pin_out_q;
    logic         pin_oe_q;
    logic [31:0]  prdata_q;
    logic         pready_q;
    logic         pslverr_q;

    timer_tick_if tk ();

    // a select change takes effect at once; the first tick after it may come early
    timer_tick_divider #(
        .DIVIDER_W (ten_bit_timer_pkg::DIV_W)
    ) u_divider (
        .pclk    (pclk),
        .presetn (presetn),
        .tk      (tk.source)
    );

    // control fields
    logic                                   counter_run;
    logic [ten_bit_timer_pkg::CMP_P_W-1:0]  compare_p_value;
    logic                                   counter_clear_select;
    logic                                   period_duty_swap;
    logic                                   output_invert;
    logic                                   output_initial_level;
    logic [1:0]                             pin_action;
    logic [1:0]                             mode_select;

    assign counter_run          = control0_q[ten_bit_timer_pkg::C0_RUN];
    assign compare_p_value      = control0_q[ten_bit_timer_pkg::C0_CMP_P_LO +: ten_bit_timer_pkg::CMP_P_W];
    assign tk.clk_select        = control0_q[ten_bit_timer_pkg::C0_CLKSEL_LO +: 2];
    assign counter_clear_select = control1_q[ten_bit_timer_pkg::C1_CLEAR_SEL];
    assign period_duty_swap     = control1_q[ten_bit_timer_pkg::C1_SWAP];
    assign output_invert        = control1_q[ten_bit_timer_pkg::C1_INVERT];
    assign output_initial_level = control1_q[ten_bit_timer_pkg::C1_INIT_LEVEL];
    assign pin_action           = control1_q[ten_bit_timer_pkg::C1_ACTION_LO +: 2];
    assign mode_select          = control1_q[ten_bit_timer_pkg::C1_MODE_LO +: 2];

    // counting and comparing
    logic         run_rise;
    logic         step;
    logic [W:0]   cnt_next;
    logic [W:0]   p_span;
    logic [W:0]   a_span;
    logic [W:0]   period_span;
    logic [W:0]   duty_span;
    logic         hit_a;
    logic         hit_p;
    logic         clear_cnt;
    logic         raise_a;
    logic         raise_p;
    logic         pwm_active;

    assign run_rise = counter_run & ~run_prev_q;
    // no step in the cycle of the run rise, so its clear always wins
    assign step     = counter_run & run_prev_q & tk.tick;
    assign cnt_next = (W+1)'(counter_q) + (W+1)'(1);

    always_comb begin
        // code 0 stands for the full 1024 span
        if (compare_p_value == '0) begin
            p_span = (W+1)'(1) << W;
        end else begin
            p_span = (W+1)'({compare_p_value, {ten_bit_timer_pkg::P_SHIFT{1'b0}}});
        end
        // software keeps compare A nonzero in compare mode; zero acts as the full span
        if (compare_a_value_q == '0) begin
            a_span = (W+1)'(1) << W;
        end else begin
            a_span = (W+1)'(compare_a_value_q);
        end
        // P sets only the top three bits and the whole next count is compared: the match lands on a multiple of 128
        hit_p = (cnt_next == p_span);
        hit_a = (cnt_next == a_span);
        clear_cnt = 1'b0;
        raise_a   = hit_a;
        raise_p   = hit_p;
        if (mode_select == ten_bit_timer_pkg::MODE_PWM) begin
            clear_cnt = period_duty_swap ? hit_a : hit_p;
        end else if (mode_select == ten_bit_timer_pkg::MODE_CAPTURE) begin
            clear_cnt = hit_p;
        end else if (counter_clear_select) begin
            clear_cnt = hit_a;
            raise_p   = 1'b0;
        end else begin
            clear_cnt = hit_p;
        end
    end

    // pwm decision: duty is held against the count itself, not the next count
    always_comb begin
        if (period_duty_swap) begin
            period_span = a_span;
            duty_span   = p_span;
        end else begin
            period_span = p_span;
            duty_span   = (W+1)'(compare_a_value_q);
        end
        // duty at or above period: active the whole period
        pwm_active = ((W+1)'(counter_q) < duty_span) || (duty_span >= period_span);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= counter_run;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_q <= '0;
        end else if (run_rise) begin
            counter_q <= '0;
        end else if (step) begin
            counter_q <= clear_cnt ? '0 : cnt_next[W-1:0];
        end
    end

    // compare-mode pin state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_state_q <= 1'b0;
        end else if (run_rise) begin
            pin_state_q <= output_initial_level;
        end else if (step && hit_a && mode_select == ten_bit_timer_pkg::MODE_COMPARE) begin
            case (pin_action)
                ten_bit_timer_pkg::ACT_LOW: begin
                    pin_state_q <= 1'b0;
                end
                ten_bit_timer_pkg::ACT_HIGH: begin
                    pin_state_q <= 1'b1;
                end
                ten_bit_timer_pkg::ACT_TOGGLE: begin
                    pin_state_q <= ~pin_state_q;
                end
                default: begin
                    pin_state_q <= pin_state_q;
                end
            endcase
        end
    end

    // registered output stage, one cycle behind the counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_q <= 1'b0;
            pin_oe_q  <= 1'b0;
        end else begin
            case (mode_select)
                ten_bit_timer_pkg::MODE_COMPARE: begin
                    pin_out_q <= pin_state_q ^ output_invert;
                    pin_oe_q  <= 1'b1;
                end
                ten_bit_timer_pkg::MODE_PWM: begin
                    pin_oe_q <= 1'b1;
                    // invert applies to the forced levels as well
                    if (pin_action == ten_bit_timer_pkg::PWM_FORCE_ACTIVE) begin
                        pin_out_q <= output_initial_level ^ output_invert;
                    end else if (pin_action == ten_bit_timer_pkg::PWM_WAVE) begin
                        pin_out_q <= (pwm_active ~^ output_initial_level) ^ output_invert;
                    end else begin
                        // single pulse is not built: it rests inactive like code 00
                        pin_out_q <= ~output_initial_level ^ output_invert;
                    end
                end
                default: begin
                    // timer/counter and capture leave the pin to other functions
                    pin_out_q <= 1'b0;
                    pin_oe_q  <= 1'b0;
                end
            endcase
        end
    end

    // apb
    logic       acc_write;
    logic       mapped;
    logic [7:0] read_byte;

    // the counter ignores writes silently; unmapped addresses are not written and answer with a slave error
    assign acc_write = psel & penable & pready_q & pwrite & ~pslverr_q;

    // counter halves are not latched together; a carry may fall between two reads
    always_comb begin
        mapped    = 1'b1;
        read_byte = 8'h00;
        if (paddr == ten_bit_timer_pkg::OFF_CONTROL0) begin
            read_byte = control0_q;
        end else if (paddr == ten_bit_timer_pkg::OFF_CONTROL1) begin
            read_byte = control1_q;
        end else if (paddr == ten_bit_timer_pkg::OFF_CNT_LOW) begin
            read_byte = counter_q[7:0];
        end else if (paddr == ten_bit_timer_pkg::OFF_CNT_HIGH) begin
            read_byte = {6'h00, counter_q[9:8]};
        end else if (paddr == ten_bit_timer_pkg::OFF_CMPA_LOW) begin
            read_byte = compare_a_value_q[7:0];
        end else if (paddr == ten_bit_timer_pkg::OFF_CMPA_HIGH) begin
            read_byte = {6'h00, compare_a_value_q[9:8]};
        end else if (paddr == ten_bit_timer_pkg::OFF_STATUS) begin
            read_byte = {6'h00, match_p_flag_q, match_a_flag_q};
        end else begin
            mapped = 1'b0;
        end
    end

    // answer is prepared in the setup cycle so every output leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= psel & ~penable;
            pslverr_q <= psel & ~penable & ~mapped;
        end
    end

    // read data stands until the next setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_q <= {24'h00_0000, read_byte};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control0_q <= ten_bit_timer_pkg::RESET_BYTE;
        end else if (acc_write && paddr == ten_bit_timer_pkg::OFF_CONTROL0) begin
            control0_q <= pwdata[7:0] & ten_bit_timer_pkg::C0_MASK;
        end
    end

    // mode and action are meant to change only while stopped; nothing enforces it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control1_q <= ten_bit_timer_pkg::RESET_BYTE;
        end else if (acc_write && paddr == ten_bit_timer_pkg::OFF_CONTROL1) begin
            control1_q <= pwdata[7:0];
        end
    end

    // halves are written independently, with no staging register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_a_value_q <= '0;
        end else if (acc_write) begin
            if (paddr == ten_bit_timer_pkg::OFF_CMPA_LOW) begin
                compare_a_value_q[7:0] <= pwdata[7:0];
            end else if (paddr == ten_bit_timer_pkg::OFF_CMPA_HIGH) begin
                compare_a_value_q[9:8] <= pwdata[1:0];
            end
        end
    end

    // sticky flags, one per comparator: a match in the clearing cycle wins
    logic       clr_status;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    logic       flag_q [2];

    assign clr_status  = acc_write && paddr == ten_bit_timer_pkg::OFF_STATUS;
    assign flag_set[0] = step && raise_a;
    assign flag_set[1] = step && raise_p;
    assign flag_clr[0] = clr_status && pwdata[ten_bit_timer_pkg::ST_MATCH_A];
    assign flag_clr[1] = clr_status && pwdata[ten_bit_timer_pkg::ST_MATCH_P];

    for (genvar i = 0; i < 2; i++) begin : g_flag
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                flag_q[i] <= 1'b0;
            end else if (flag_set[i]) begin
                flag_q[i] <= 1'b1;
            end else if (flag_clr[i]) begin
                flag_q[i] <= 1'b0;
            end
        end
    end

    assign match_a_flag_q = flag_q[0];
    assign match_p_flag_q = flag_q[1];

    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign timer_output_pin    = pin_out_q;
    assign timer_output_enable = pin_oe_q;
endmodule

// ### rtl/ten_bit_timer_pkg.sv
package ten_bit_timer_pkg;

    localparam int unsigned CNT_W = 10;
    localparam int unsigned CMP_P_W = 3;
    localparam int unsigned P_SHIFT = 7;

    // register byte addresses
    localparam logic [7:0] OFF_CONTROL0 = 8'h00;
    localparam logic [7:0] OFF_CONTROL1 = 8'h04;
    localparam logic [7:0] OFF_CNT_LOW = 8'h08;
    localparam logic [7:0] OFF_CNT_HIGH = 8'h0c;
    localparam logic [7:0] OFF_CMPA_LOW = 8'h10;
    localparam logic [7:0] OFF_CMPA_HIGH = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;

    // control0 fields
    localparam int unsigned C0_RUN = 3;
    localparam int unsigned C0_CLKSEL_LO = 4;
    localparam int unsigned C0_CMP_P_LO = 0;
    localparam logic [7:0] C0_MASK = 8'h3f;

    // control1 fields
    localparam int unsigned C1_CLEAR_SEL = 0;
    localparam int unsigned C1_SWAP = 1;
    localparam int unsigned C1_INVERT = 2;
    localparam int unsigned C1_INIT_LEVEL = 3;
    localparam int unsigned C1_ACTION_LO = 4;
    localparam int unsigned C1_MODE_LO = 6;

    // status fields, write one to clear
    localparam int unsigned ST_MATCH_A = 0;
    localparam int unsigned ST_MATCH_P = 1;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    // mode_select encodings
    localparam logic [1:0] MODE_COMPARE = 2'h0;
    localparam logic [1:0] MODE_CAPTURE = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TIMER = 2'h3;

    // pin_action encodings
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] PWM_FORCE_INACTIVE = 2'h0;
    localparam logic [1:0] PWM_FORCE_ACTIVE = 2'h1;
    localparam logic [1:0] PWM_WAVE = 2'h2;

    // timer clock divide ratios as log2, per clock select code
    localparam int unsigned DIV_W = 6;
    localparam logic [2:0] DIV_LOG2_0 = 3'h0;
    localparam logic [2:0] DIV_LOG2_1 = 3'h2;
    localparam logic [2:0] DIV_LOG2_2 = 3'h4;
    localparam logic [2:0] DIV_LOG2_3 = 3'h6;

endpackage

// ### rtl/timer_tick_divider.sv
`timescale 1ns/1ns
module timer_tick_divider #(
    parameter int unsigned DIVIDER_W = ten_bit_timer_pkg::DIV_W
) (
    input  wire logic pclk,
    input  wire logic presetn,
    timer_tick_if.source tk
);
    logic [DIVIDER_W-1:0] div_q;
    logic [2:0]           log2_sel;
    logic [DIVIDER_W-1:0] wrap_mask;
    logic                 tick_q;

    if (DIVIDER_W < ten_bit_timer_pkg::DIV_W) begin : g_width_check
        $error("divider too narrow for the largest ratio");
    end

    always_comb begin
        if (tk.clk_select == 2'h0) begin
            log2_sel = ten_bit_timer_pkg::DIV_LOG2_0;
        end else if (tk.clk_select == 2'h1) begin
            log2_sel = ten_bit_timer_pkg::DIV_LOG2_1;
        end else if (tk.clk_select == 2'h2) begin
            log2_sel = ten_bit_timer_pkg::DIV_LOG2_2;
        end else begin
            log2_sel = ten_bit_timer_pkg::DIV_LOG2_3;
        end
        wrap_mask = DIVIDER_W'((1 << log2_sel) - 1);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= DIVIDER_W'(div_q + 1'b1);
            // one pulse per ratio; a select change only shifts the phase once
            tick_q <= ((div_q & wrap_mask) == wrap_mask);
        end
    end

    assign tk.tick = tick_q;
endmodule

// ### rtl/timer_tick_if.sv
`timescale 1ns/1ns
interface timer_tick_if;
    logic [1:0] clk_select;
    logic       tick;

    modport source (input clk_select, output tick);
    modport sink   (output clk_select, input tick);
endinterface

// ### tb/ten_bit_compare_pwm_timer_test.sv
`timescale 1ns/1ns
module ten_bit_compare_pwm_timer_test;
    typedef struct packed {
        logic [7:0]  c1;
        logic [9:0]  a;
        logic [2:0]  p;
        logic [31:0] hi;
        logic [31:0] per;
        logic [7:0]  st;
    } row_t;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin;
    logic        pin_en;
    logic [31:0] rd;
    logic        sl;
    int          mismatches;
    int          checked;
    int          hi;
    int          per;
    row_t        rows [9];

    ten_bit_compare_pwm_timer ten_bit_compare_pwm_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_output_pin(pin), .timer_output_enable(pin_en));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        check(n < 50, 1'b1);
        rd = prdata;
        sl = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // mode and action change only while stopped
    task cfg(input logic [7:0] c1, input logic [9:0] a, input logic [2:0] p);
        apb(1'b1, 8'h00, 8'h00);
        apb(1'b1, 8'h10, a[7:0]);
        apb(1'b1, 8'h14, {6'h0, a[9:8]});
        apb(1'b1, 8'h04, c1);
        apb(1'b1, 8'h18, 8'h03);
        apb(1'b1, 8'h00, {5'h01, p});
    endtask

    task span(input logic v, output int c);
        c = 0;
        while (pin === v && c < 3000) begin
            @(posedge pclk);
            c++;
        end
    endtask

    // skip the partial phase first, so only whole periods are timed
    task measure;
        int low;
        span(1'b1, hi);
        span(1'b0, hi);
        span(1'b1, hi);
        span(1'b0, low);
        per = hi + low;
    endtask

    task test_done;
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        #400000;
        mismatches++;
        test_done;
    end

    initial begin
        logic [31:0] cnt;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        mismatches = 0;
        checked = 0;
        rows = '{'{8'ha8, 10'd64, 3'd1, 64, 128, 8'h03}, '{8'haa, 10'd256, 3'd1, 128, 256, 8'h03},
                 '{8'ha8, 10'd100, 3'd7, 100, 896, 8'h03}, '{8'hac, 10'd32, 3'd1, 96, 128, 8'h03},
                 '{8'ha0, 10'd32, 3'd1, 96, 128, 8'h03}, '{8'ha9, 10'd64, 3'd1, 64, 128, 8'h03},
                 '{8'h30, 10'd64, 3'd1, 128, 256, 8'h03}, '{8'h31, 10'd300, 3'd1, 300, 600, 8'h01},
                 '{8'h30, 10'd5, 3'd0, 1024, 2048, 8'h03}};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            cfg(rows[i].c1, rows[i].a, rows[i].p);
            measure;
            check(hi, rows[i].hi);
            check(per, rows[i].per);
            apb(1'b0, 8'h18, 8'h00);
            check(rd, {24'h0, rows[i].st});
        end
        // action 11 is the unbuilt single pulse: it must rest inactive
        for (int k = 0; k < 4; k++) begin
            cfg(8'h88 | 8'(k << 4), 10'd200, 3'd1);
            repeat (300) @(posedge pclk);
            check(pin, k == 1 || k == 2);
        end
        // timer mode, then capture with clear select set, which it must ignore
        for (int k = 0; k < 2; k++) begin
            cfg(k == 0 ? 8'hf0 : 8'h71, 10'd64, 3'd1);
            repeat (300) @(posedge pclk);
            check({pin_en, pin}, 2'b00);
            apb(1'b0, 8'h18, 8'h00);
            check(rd, 32'h03);
        end
        cfg(8'h20, 10'd64, 3'd1);
        repeat (100) @(posedge pclk);
        check(pin, 1'b1);
        apb(1'b1, 8'h00, 8'h01);
        apb(1'b0, 8'h08, 8'h00);
        cnt = rd;
        repeat (20) @(posedge pclk);
        apb(1'b0, 8'h08, 8'h00);
        check(rd, cnt);
        apb(1'b0, 8'h18, 8'h00);
        check(rd, 32'h01);
        apb(1'b1, 8'h18, 8'h03);
        apb(1'b0, 8'h18, 8'h00);
        check(rd, 32'h00);
        apb(1'b1, 8'h00, 8'h09);
        repeat (5) @(posedge pclk);
        check(pin, 1'b0);
        apb(1'b1, 8'h1c, 8'hff);
        check(sl, 1'b1);
        apb(1'b0, 8'h1c, 8'h00);
        check({sl, rd}, {1'b1, 32'h0});
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            apb(1'b0, 8'(k * 4), 8'h00);
            check(rd, 32'h0);
        end
        for (int k = 2; k < 6; k++) begin
            apb(1'b1, 8'(k * 4), 8'ha5);
        end
        for (int k = 2; k < 6; k++) begin
            apb(1'b0, 8'(k * 4), 8'h00);
            check(rd, k == 4 ? 32'ha5 : k == 5 ? 32'h01 : 32'h0);
        end
        test_done;
    end
endmodule

bind ten_bit_compare_pwm_timer ten_bit_timer_checker ten_bit_timer_checker_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_output_pin(timer_output_pin),
    .timer_output_enable(timer_output_enable));

// ### tb/ten_bit_timer_checker.sv
`timescale 1ns/1ns
module ten_bit_timer_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        timer_output_pin,
    input wire logic        timer_output_enable
);
    logic       wr;
    logic       rd;
    logic       unmapped;
    logic       forced;
    logic       run_q;
    logic [7:0] ctl1_q;
    logic [7:0] cmpa_lo_q;

    assign wr = psel && penable && pready && pwrite;
    assign rd = psel && penable && pready && !pwrite;
    assign unmapped = paddr[1:0] != 2'h0 || paddr > ten_bit_timer_pkg::OFF_STATUS;
    // force codes only, so waveform and single pulse stay out
    assign forced = ctl1_q[7:6] == ten_bit_timer_pkg::MODE_PWM && !ctl1_q[5] && run_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl1_q <= 8'h00;
        end else if (wr && paddr == ten_bit_timer_pkg::OFF_CONTROL1) begin
            ctl1_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
        end else if (wr && paddr == ten_bit_timer_pkg::OFF_CONTROL0) begin
            run_q <= pwdata[3];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmpa_lo_q <= 8'h00;
        end else if (wr && paddr == ten_bit_timer_pkg::OFF_CMPA_LOW) begin
            cmpa_lo_q <= pwdata[7:0];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready_after_setup; psel && !penable |=> pready; endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("no ready after setup");
    property p_ready_single; pready |=> !pready; endproperty
    a_ready_single: assert property (p_ready_single)
        else $error("ready held too long");
    property p_err_decode; psel && !penable |=> pslverr == $past(unmapped); endproperty
    a_err_decode: assert property (p_err_decode)
        else $error("slave error does not match decode");
    property p_err_with_ready; pslverr |-> pready; endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("slave error without ready");
    property p_read_upper_zero; rd |-> prdata[31:8] == 24'h0; endproperty
    a_read_upper_zero: assert property (p_read_upper_zero)
        else $error("read data upper bits set");
    property p_high_bits_zero;
        rd && (paddr == ten_bit_timer_pkg::OFF_CNT_HIGH || paddr == ten_bit_timer_pkg::OFF_CMPA_HIGH)
            |-> prdata[7:2] == 6'h0;
    endproperty
    a_high_bits_zero: assert property (p_high_bits_zero)
        else $error("unimplemented high bits read nonzero");
    property p_cmpa_readback; rd && paddr == ten_bit_timer_pkg::OFF_CMPA_LOW |-> prdata[7:0] == cmpa_lo_q; endproperty
    a_cmpa_readback: assert property (p_cmpa_readback)
        else $error("compare low byte readback wrong");
    property p_timer_quiet;
        (ctl1_q[7:6] == ten_bit_timer_pkg::MODE_TIMER)[*3] |-> !timer_output_enable && !timer_output_pin;
    endproperty
    a_timer_quiet: assert property (p_timer_quiet)
        else $error("pin driven in timer mode");
    property p_pwm_force; forced[*4] |-> timer_output_pin == (ctl1_q[3] ^ ctl1_q[2] ^ !ctl1_q[4]); endproperty
    a_pwm_force: assert property (p_pwm_force)
        else $error("forced pin level wrong");
    property p_pwm_drives; (ctl1_q[7:6] == ten_bit_timer_pkg::MODE_PWM && run_q)[*3] |-> timer_output_enable; endproperty
    a_pwm_drives: assert property (p_pwm_drives)
        else $error("pin not driven in waveform mode");
endmodule
